// ---- logic/eac_pkg.sv ----
// constants and carrier types for the eeprom access control block
// assumes a cpu core on sys_clk issuing single-cycle register accesses
package eac_pkg;
    // -------------------------------------------------------------
    // register select codes on the core's register port
    // -------------------------------------------------------------
    localparam logic [1:0] SEL_CONTROL = 2'h0;
    localparam logic [1:0] SEL_ADDR_LO = 2'h1;
    localparam logic [1:0] SEL_ADDR_HI = 2'h2;
    localparam logic [1:0] SEL_DATA = 2'h3;

    // -------------------------------------------------------------
    // control register fields and reset values
    // -------------------------------------------------------------
    localparam int BIT_READ_STROBE = 0;
    localparam int BIT_WRITE_STROBE = 1;
    localparam int BIT_MASTER_ARM = 2;
    localparam int BIT_READY_IRQ_EN = 3;
    localparam logic [3:0] CTRL_RSVD_VALUE = 4'h0;
    localparam logic [8:0] ADDR_RESET = 9'h000;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam int ADDR_W = 9;
    localparam int ARRAY_BYTES = 512;

    // -------------------------------------------------------------
    // timing counts
    // -------------------------------------------------------------
    localparam int OSC_FREQ_KHZ = 1000;
    localparam int WR_OSC_CYCLES = 8448;
    localparam logic [1:0] ARM_LAST = 2'h3;
    localparam logic [2:0] WR_STALL_CYCLES = 3'h2;
    localparam logic [2:0] RD_STALL_CYCLES = 3'h4;

    typedef struct packed {
        logic [1:0] sel;
        logic wr;
        logic [7:0] wdata;
    } eac_io_req_t;

    typedef enum logic [1:0] {
        EAC_IDLE = 2'b01,
        EAC_PROG = 2'b10
    } eac_wr_state_t;
endpackage

// ---- logic/eac_eeprom_access_control.sv ----
// eeprom access control: control, address and data registers plus the
// self-timed byte write engine and the 512-byte data array
// assumes the core holds off its next instruction while cpu_stall_ff is high
// How it works
// - control bits 7..4 always read zero
// - ready irq needs enable and global enable
// - ready irq is a level while idle
// - strobe within four clocks of arm writes
// - strobe without arm does nothing
// - arm bit self-clears after four clocks
// - strobe programs held data at held address
// - strobe refused during flash self-programming; a write already running still completes
// - strobe bit clears when programming ends
// - write start stalls the core two cycles
// - read strobe loads data, stalls four cycles
// - reads and address changes blocked while busy
// - write lasts 8448 calibrated oscillator cycles
// - core reset does not abort a write
// - nine-bit address, upper high bits zero
// - data register feeds writes, receives reads
`timescale 1ns/1ps
module eac_eeprom_access_control #(
    parameter int unsigned WRITE_OSC_CYCLES = eac_pkg::WR_OSC_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic power_ok_n,
    input wire eac_pkg::eac_io_req_t io_req,
    input wire logic core_irq_enable,
    input wire logic self_prog_active,
    input wire logic cal_osc_clk,
    output logic [7:0] io_rdata_ff,
    output logic ready_irq_ff,
    output logic cpu_stall_ff
);
    import eac_pkg::*;

    // -------------------------------------------------------------
    // register access decode
    // -------------------------------------------------------------
    function automatic logic sel_wr(input eac_io_req_t r, input logic [1:0] s);
        sel_wr = r.wr && (r.sel == s);
    endfunction

    logic ready_irq_en_ff;
    logic arm_ff;
    logic [1:0] arm_cnt_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [7:0] data_ff;
    logic [2:0] stall_cnt_ff;
    eac_wr_state_t state_ff;
    eac_wr_state_t nxt_state;
    logic [13:0] osc_cnt_ff;
    logic [ADDR_W-1:0] prog_addr_ff;
    logic [7:0] prog_data_ff;
    logic osc_s1_ff;
    logic osc_s2_ff;
    logic osc_s3_ff;
    logic [7:0] mem [0:ARRAY_BYTES-1];

    logic ctrl_wr;
    logic busy;
    logic start_wr;
    logic start_rd;
    logic osc_tick;
    logic prog_done;

    assign ctrl_wr = sel_wr(io_req, SEL_CONTROL);
    assign busy = (state_ff == EAC_PROG);
    assign start_wr = ctrl_wr && io_req.wdata[BIT_WRITE_STROBE] && arm_ff && !busy
        && !self_prog_active;
    assign start_rd = ctrl_wr && io_req.wdata[BIT_READ_STROBE] && !busy;
    assign osc_tick = osc_s2_ff && !osc_s3_ff;
    assign prog_done = busy && osc_tick && (osc_cnt_ff == 14'(WRITE_OSC_CYCLES - 1));

    // -------------------------------------------------------------
    // core-side control bits
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            ready_irq_en_ff <= 1'b0;
        else if (ctrl_wr)
            ready_irq_en_ff <= io_req.wdata[BIT_READY_IRQ_EN];
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            arm_ff <= 1'b0;
            arm_cnt_ff <= 2'h0;
        end
        else if (ctrl_wr && io_req.wdata[BIT_MASTER_ARM])
        begin
            arm_ff <= 1'b1;
            arm_cnt_ff <= 2'h0;
        end
        else if (arm_ff)
        begin
            arm_ff <= (arm_cnt_ff != ARM_LAST);
            arm_cnt_ff <= arm_cnt_ff + 2'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            addr_ff <= ADDR_RESET;
        else if (!busy && sel_wr(io_req, SEL_ADDR_LO))
            addr_ff[7:0] <= io_req.wdata;
        else if (!busy && sel_wr(io_req, SEL_ADDR_HI))
            addr_ff[8] <= io_req.wdata[0];
    end

    // read lands in the data register at once
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            data_ff <= DATA_RESET;
        else if (start_rd)
            data_ff <= mem[addr_ff];
        else if (sel_wr(io_req, SEL_DATA))
            data_ff <= io_req.wdata;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stall_cnt_ff <= 3'h0;
            cpu_stall_ff <= 1'b0;
        end
        else if (start_wr)
        begin
            stall_cnt_ff <= WR_STALL_CYCLES - 3'h1;
            cpu_stall_ff <= 1'b1;
        end
        else if (start_rd)
        begin
            stall_cnt_ff <= RD_STALL_CYCLES - 3'h1;
            cpu_stall_ff <= 1'b1;
        end
        else
        begin
            stall_cnt_ff <= (stall_cnt_ff != 3'h0) ? stall_cnt_ff - 3'h1 : 3'h0;
            cpu_stall_ff <= (stall_cnt_ff != 3'h0);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            io_rdata_ff <= 8'h00;
        else
            case (io_req.sel)
                SEL_CONTROL: io_rdata_ff <= {CTRL_RSVD_VALUE, ready_irq_en_ff, arm_ff, busy, 1'b0};
                SEL_ADDR_LO: io_rdata_ff <= addr_ff[7:0];
                SEL_ADDR_HI: io_rdata_ff <= {7'h00, addr_ff[8]};
                default: io_rdata_ff <= data_ff;
            endcase
    end

    // level request whenever both enables are set and the engine is idle
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            ready_irq_ff <= 1'b0;
        else
            ready_irq_ff <= ready_irq_en_ff && core_irq_enable && !busy;
    end

    // -------------------------------------------------------------
    // write engine, on the supply reset only
    // -------------------------------------------------------------
    // oscillator is asynchronous to sys_clk; s3 only serves edge detect
    always_ff @(posedge sys_clk or negedge power_ok_n)
    begin
        if (!power_ok_n)
        begin
            osc_s1_ff <= 1'b0;
            osc_s2_ff <= 1'b0;
            osc_s3_ff <= 1'b0;
        end
        else
        begin
            osc_s1_ff <= cal_osc_clk;
            osc_s2_ff <= osc_s1_ff;
            osc_s3_ff <= osc_s2_ff;
        end
    end

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            EAC_IDLE: if (start_wr) nxt_state = EAC_PROG;
            EAC_PROG: if (prog_done) nxt_state = EAC_IDLE;
            default: nxt_state = EAC_IDLE;
        endcase
    end

    // busy survives a core reset, clears at the end
    always_ff @(posedge sys_clk or negedge power_ok_n)
    begin
        if (!power_ok_n)
            state_ff <= EAC_IDLE;
        else
            state_ff <= nxt_state;
    end

    always_ff @(posedge sys_clk or negedge power_ok_n)
    begin
        if (!power_ok_n)
            osc_cnt_ff <= 14'h0000;
        else if (!busy)
            osc_cnt_ff <= 14'h0000;
        else if (osc_tick)
            osc_cnt_ff <= osc_cnt_ff + 14'h0001;
    end

    // latch byte and address at launch
    always_ff @(posedge sys_clk or negedge power_ok_n)
    begin
        if (!power_ok_n)
        begin
            prog_addr_ff <= ADDR_RESET;
            prog_data_ff <= DATA_RESET;
        end
        else if (start_wr)
        begin
            prog_addr_ff <= addr_ff;
            prog_data_ff <= data_ff;
        end
    end

    // array cells carry no reset, like the real cells
    always_ff @(posedge sys_clk)
    begin
        if (prog_done)
            mem[prog_addr_ff] <= prog_data_ff;
    end

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    a_rsvd_read_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $past(io_req.sel) == SEL_CONTROL |-> io_rdata_ff[7:4] == 4'h0)
        else $error("control spare bits not zero");
    a_irq_gating: assert property (@(posedge sys_clk) disable iff (!reset_n || !power_ok_n)
        !ready_irq_en_ff || !core_irq_enable |=> !ready_irq_ff)
        else $error("ready irq without enables");
    a_irq_level: assert property (@(posedge sys_clk) disable iff (!reset_n || !power_ok_n)
        ready_irq_en_ff && core_irq_enable && !busy ##1 ready_irq_en_ff && core_irq_enable
        && !busy |=> ready_irq_ff[*1] ##0 $past(ready_irq_ff))
        else $error("ready irq not held as a level");
    a_arm_window: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(arm_ff) ##0 !ctrl_wr [*4] |-> arm_ff [*4] ##1 !arm_ff)
        else $error("arm bit did not time out after four clocks");
    a_write_launch: assert property (@(posedge sys_clk) disable iff (!reset_n || !power_ok_n)
        !busy && ctrl_wr && io_req.wdata[BIT_WRITE_STROBE] && arm_ff && !self_prog_active
        |=> busy)
        else $error("armed strobe did not start a write");
    a_no_arm_no_write: assert property (@(posedge sys_clk) disable iff (!reset_n || !power_ok_n)
        !busy && !arm_ff |=> !busy)
        else $error("write started without arm");
    a_spm_block: assert property (@(posedge sys_clk) disable iff (!reset_n || !power_ok_n)
        !busy && self_prog_active |=> !busy)
        else $error("write started during self programming");
    a_wr_stall: assert property (@(posedge sys_clk) disable iff (!reset_n || !power_ok_n)
        start_wr ##1 !ctrl_wr |-> cpu_stall_ff [*2] ##1 !cpu_stall_ff)
        else $error("write stall not two cycles");
    a_rd_stall: assert property (@(posedge sys_clk) disable iff (!reset_n || !power_ok_n)
        start_rd |=> cpu_stall_ff [*4] ##1 !cpu_stall_ff)
        else $error("read stall not four cycles");
    a_addr_frozen: assert property (@(posedge sys_clk) disable iff (!reset_n || !power_ok_n)
        busy |=> $stable(addr_ff))
        else $error("address changed while busy");
    a_done_clears: assert property (@(posedge sys_clk) disable iff (!power_ok_n)
        prog_done |=> !busy)
        else $error("strobe bit not cleared at write end");

    c_write_start: cover property (@(posedge sys_clk) disable iff (!reset_n) start_wr);
    c_write_done: cover property (@(posedge sys_clk) disable iff (!power_ok_n) prog_done);
    c_read: cover property (@(posedge sys_clk) disable iff (!reset_n) start_rd);
    c_arm_expire: cover property (@(posedge sys_clk) disable iff (!reset_n) $fell(arm_ff));
endmodule

// ---- testbench/eac_cpu_model.sv ----
// cpu core model: single-cycle register accesses to the block
// assumes callers enter its tasks at a falling edge of sys_clk
`timescale 1ns/1ps
module eac_cpu_model
    import eac_pkg::*;
(
    input wire logic sys_clk,
    input wire logic cpu_stall_ff,
    input wire logic [7:0] io_rdata_ff,
    output eac_pkg::eac_io_req_t io_req
);
    time last_rel = 0;
    initial io_req = '0;
    task automatic hold_off();
        int n;
        n = 0;
        while (cpu_stall_ff !== 1'b0 && n < 16)
        begin
            @(negedge sys_clk);
            n++;
        end
    endtask
    task automatic wr(input logic [1:0] s, input logic [7:0] d);
        hold_off();
        // back-to-back write: let an edge pass, wr never drops and rises at once
        if (last_rel == $time)
            @(negedge sys_clk);
        io_req = '{sel: s, wr: 1'b1, wdata: d};
        @(negedge sys_clk);
        io_req.wr = 1'b0;
        // stale bus data would hide a late capture
        io_req.wdata = ~d;
        last_rel = $time;
    endtask
    task automatic rd(input logic [1:0] s, output logic [7:0] d);
        hold_off();
        io_req.sel = s;
        @(negedge sys_clk);
        d = io_rdata_ff;
    endtask
endmodule

// ---- testbench/test_eeprom_access_control.sv ----
// bench for the eeprom access control block
// assumes the cpu model makes every register access
`timescale 1ns/1ps
module test_eeprom_access_control;
    import eac_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic power_ok_n = 1'b0;
    logic core_irq_enable = 1'b0;
    logic self_prog_active = 1'b0;
    logic cal_osc_clk = 1'b0;
    eac_io_req_t io_req;
    logic [7:0] io_rdata_ff;
    logic ready_irq_ff;
    logic cpu_stall_ff;
    logic [7:0] v;
    int n_mismatch = 0;
    int num_checks = 0;
    always #20 sys_clk = ~sys_clk;
    // odd half period keeps osc phase apart
    always #203 cal_osc_clk = ~cal_osc_clk;
    eac_eeprom_access_control #(.WRITE_OSC_CYCLES(6)) dut_u (
        .sys_clk(sys_clk), .reset_n(reset_n), .power_ok_n(power_ok_n),
        .io_req(io_req), .core_irq_enable(core_irq_enable),
        .self_prog_active(self_prog_active), .cal_osc_clk(cal_osc_clk),
        .io_rdata_ff(io_rdata_ff), .ready_irq_ff(ready_irq_ff),
        .cpu_stall_ff(cpu_stall_ff));
    eac_cpu_model cpu_u (.sys_clk(sys_clk), .cpu_stall_ff(cpu_stall_ff),
        .io_rdata_ff(io_rdata_ff), .io_req(io_req));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic irq(input string nm, input logic e);
        chk(nm, {7'h00, e}, {7'h00, ready_irq_ff});
    endtask
    task automatic stalls(output logic [7:0] c);
        c = 8'h00;
        repeat (8)
        begin
            c = c + {7'h00, cpu_stall_ff};
            @(negedge sys_clk);
        end
    endtask
    task automatic seta(input logic [8:0] a);
        cpu_u.wr(SEL_ADDR_LO, a[7:0]);
        cpu_u.wr(SEL_ADDR_HI, {7'h00, a[8]});
    endtask
    task automatic launch(input logic [7:0] en, input int gap);
        cpu_u.wr(SEL_CONTROL, en | 8'h04);
        repeat (gap) @(negedge sys_clk);
        cpu_u.wr(SEL_CONTROL, en | 8'h02);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        v = 8'h02;
        while (v[1] !== 1'b0 && n < 300)
        begin
            cpu_u.rd(SEL_CONTROL, v);
            n++;
        end
    endtask
    task automatic fetch(input logic [8:0] a, input logic [7:0] d);
        logic [7:0] c;
        seta(a);
        cpu_u.wr(SEL_CONTROL, 8'h01);
        stalls(c);
        chk("read stall", {5'h00, RD_STALL_CYCLES}, c);
        cpu_u.rd(SEL_DATA, v);
        chk("read data", d, v);
    endtask
    task automatic t_reset();
        cpu_u.rd(SEL_CONTROL, v);
        chk("ctrl reset", 8'h00, v);
        cpu_u.rd(SEL_DATA, v);
        chk("data reset", DATA_RESET, v);
        irq("irq reset", 1'b0);
        $display("done reset");
    endtask
    task automatic t_write(input logic [8:0] a, input logic [7:0] d);
        logic [7:0] c;
        seta(a);
        cpu_u.wr(SEL_DATA, d);
        // strobe on the last armed cycle
        launch(8'h00, 3);
        stalls(c);
        chk("write stall", {5'h00, WR_STALL_CYCLES}, c);
        cpu_u.rd(SEL_CONTROL, v);
        chk("busy ctrl", 8'h02, v);
        cpu_u.wr(SEL_DATA, ~d);
        seta(~a);
        cpu_u.wr(SEL_CONTROL, 8'h01);
        stalls(c);
        cpu_u.rd(SEL_DATA, v);
        chk("data busy", ~d, v);
        cpu_u.rd(SEL_ADDR_LO, v);
        chk("addr busy", a[7:0], v);
        wait_idle();
        chk("idle ctrl", 8'h00, v);
        cpu_u.rd(SEL_ADDR_HI, v);
        chk("addr hi", {7'h00, a[8]}, v);
        fetch(a, d);
        $display("done write %h", a);
    endtask
    task automatic t_refuse();
        seta(9'h1ff);
        cpu_u.wr(SEL_DATA, 8'h77);
        cpu_u.wr(SEL_CONTROL, 8'h02);
        cpu_u.rd(SEL_CONTROL, v);
        chk("no arm", 8'h00, v);
        cpu_u.wr(SEL_CONTROL, 8'h04);
        cpu_u.rd(SEL_CONTROL, v);
        chk("armed", 8'h04, v);
        repeat (4) @(negedge sys_clk);
        cpu_u.rd(SEL_CONTROL, v);
        chk("arm expired", 8'h00, v);
        cpu_u.wr(SEL_CONTROL, 8'h02);
        self_prog_active = 1'b1;
        launch(8'h00, 0);
        cpu_u.rd(SEL_CONTROL, v);
        chk("self prog", 8'h04, v);
        self_prog_active = 1'b0;
        fetch(9'h1ff, 8'ha5);
        $display("done refuse");
    endtask
    task automatic t_irq();
        cpu_u.wr(SEL_CONTROL, 8'h08);
        repeat (2) @(negedge sys_clk);
        irq("irq gated", 1'b0);
        core_irq_enable = 1'b1;
        repeat (8) @(negedge sys_clk);
        irq("irq level", 1'b1);
        launch(8'h08, 1);
        repeat (3) @(negedge sys_clk);
        irq("irq busy", 1'b0);
        wait_idle();
        repeat (2) @(negedge sys_clk);
        irq("irq ready", 1'b1);
        cpu_u.wr(SEL_CONTROL, 8'h00);
        repeat (2) @(negedge sys_clk);
        irq("irq off", 1'b0);
        core_irq_enable = 1'b0;
        $display("done irq");
    endtask
    task automatic t_rst();
        seta(9'h000);
        cpu_u.wr(SEL_DATA, 8'h5a);
        launch(8'h00, 0);
        repeat (10) @(negedge sys_clk);
        reset_n = 1'b0;
        @(negedge sys_clk);
        reset_n = 1'b1;
        cpu_u.rd(SEL_CONTROL, v);
        chk("busy after rst", 8'h02, v);
        cpu_u.rd(SEL_DATA, v);
        chk("data after rst", DATA_RESET, v);
        wait_idle();
        fetch(9'h000, 8'h5a);
        $display("done reset in write");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        n_mismatch++;
        finish_test();
    end
    initial
    begin
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        reset_n = 1'b1;
        power_ok_n = 1'b1;
        t_reset();
        t_write(9'h1ff, 8'ha5);
        t_write(9'h000, 8'h3c);
        t_refuse();
        t_irq();
        t_rst();
        finish_test();
    end
endmodule
